//--- verilog/qdac_pkg.sv
// qdac_pkg: constants shared by the quad converter update and reset control.
// assumes one 24-bit command word per write, command code in the top nibble.
// How it works
// - write-input with strobe low updates both registers
// - write-input with strobe high updates input only
// - strobe falling edge copies input to converter
// - update command copies input to converter
// - write-and-update loads both registers always
// - mask command loads low four data bits
// - mask bits 3..0 map channels d..a
// - mask resets to zero, all channels respond
// - masked channel ignores every strobe transition
// - each strobe fall updates every unmasked channel
// - strobe held low makes mask irrelevant
// - reset pin clears outputs to selected code
// - no updates while reset pin low
// - software reset acts like power-on reset
// - strobe events ignored during power-on reset
// - initialisation waits for reset pin release
// - power-up code zero or midscale by select
// - outputs hold power-up code until written
// - word is command, address, then data bits
package qdac_pkg;

  // ==========================================================
  // command word layout
  localparam int WORD_BITS = 24; // whole command word
  localparam int CMD_MSB = 23; // command nibble top
  localparam int CMD_LSB = 20; // command nibble bottom
  localparam int ADDR_MSB = 19; // channel select, bit per channel
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15; // data is msb aligned
  localparam int MASK_MSB = 3; // mask lives in db3..db0
  localparam int NUM_CH = 4; // channels a..d

  // ==========================================================
  // command codes
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_WRITE_INPUT = 4'h1,
    CMD_UPDATE = 4'h2,
    CMD_WRITE_UPDATE = 4'h3,
    CMD_POWER_DOWN = 4'h4,
    CMD_MASK = 4'h5,
    CMD_SOFT_RESET = 4'h6
  } qdac_cmd_type;

  // ==========================================================
  // reset values and byte framing
  localparam logic [3:0] MASK_RESET = 4'h0; // all channels follow the strobe
  localparam logic [3:0] BYTE_BITS = 4'h8; // data bits per byte
  localparam logic [3:0] LAST_BIT = 4'h7; // index of the final bit of a byte
  localparam logic [1:0] LAST_BYTE = 2'h2; // third byte after the address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h0C; // arbitrary bus address

endpackage : qdac_pkg

//--- verilog/qdac_chan_if.sv
// qdac_chan_if: control bundle from the update logic to one channel.
// assumes one instance per channel, all on the system clock.
`timescale 1ns/100ps
`default_nettype none
interface qdac_chan_if #(
  parameter int DATA_W = 16
);
  logic clear; // hold both registers at clear_code
  logic [DATA_W-1:0] clear_code; // zero scale or midscale
  logic load_input; // write data into input register
  logic dac_from_data; // write data into converter register
  logic dac_from_input; // copy input register to converter register
  logic [DATA_W-1:0] data; // data field of the word
  logic [DATA_W-1:0] dac_code; // word presented to the converter core

  modport ctrl (output clear, clear_code, load_input, dac_from_data, dac_from_input, data, input dac_code);
  modport chan (input clear, clear_code, load_input, dac_from_data, dac_from_input, data, output dac_code);
endinterface : qdac_chan_if
`default_nettype wire

//--- verilog/qdac_sync.sv
// qdac_sync: two-flop synchroniser for pins from outside the clock domain.
// assumes levels only; edges are found downstream on the second flop.
`timescale 1ns/100ps
`default_nettype none
module qdac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // pins in, levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta; // first stage, read only by second stage

  // ==========================================================
  // two stage capture
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else if (clk_en_i) begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : qdac_sync
`default_nettype wire

//--- verilog/qdac_channel.sv
// qdac_channel: input register and converter register of one channel.
// assumes the controller never asks for two loads it cannot order; clear wins.
`timescale 1ns/100ps
`default_nettype none
module qdac_channel #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // control bundle
  qdac_chan_if.chan bus
);
  logic [DATA_W-1:0] input_reg; // staged value, not yet on the output

  // ==========================================================
  // input register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      input_reg <= '0;
    end else if (clk_en_i) begin
      if (bus.clear) begin
        input_reg <= bus.clear_code;
      end else if (bus.load_input) begin
        input_reg <= bus.data;
      end
    end
  end

  // ==========================================================
  // converter register, the only source of the output word
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus.dac_code <= '0;
    end else if (clk_en_i) begin
      if (bus.clear) begin
        bus.dac_code <= bus.clear_code;
      end else if (bus.dac_from_data) begin
        bus.dac_code <= bus.data;
      end else if (bus.dac_from_input) begin
        bus.dac_code <= input_reg;
      end
      // otherwise hold: output moves only on an update
    end
  end
endmodule : qdac_channel
`default_nettype wire

//--- verilog/qdac_ctrl.sv
// qdac_ctrl: two-wire write receiver, command decode, load strobe and reset
// control for a quad double-buffered converter.
// assumes scl and sda arrive from pins; sda is open drain, resolved outside.
`timescale 1ns/100ps
`default_nettype none
module qdac_ctrl #(
  parameter int DATA_W = 16,
  parameter logic [6:0] DEV_ADDR = qdac_pkg::DEV_ADDR_DEFAULT
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // two-wire serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // control pins
  input wire logic load_strobe_n_i,
  input wire logic reset_n_i,
  input wire logic reset_level_select_i,
  // converter core side
  output logic [qdac_pkg::NUM_CH*DATA_W-1:0] dac_code_o,
  output logic init_busy_o
);

  // ==========================================================
  // elaboration check
  if (DATA_W < 2 || DATA_W > qdac_pkg::DATA_MSB + 1) begin : g_bad_width
    $error("qdac_ctrl: DATA_W must lie between 2 and 16");
  end

  // ==========================================================
  // synchronised pins
  logic scl_s; // link clock level
  logic sda_s; // link data level
  logic ls_s; // load strobe level, active low
  logic rst_pin_s; // reset pin level, active low
  logic rsel_s; // reset level select level

  // link pins idle high; reset pin starts as asserted so power-up waits
  qdac_sync #(
    .WIDTH(5),
    .RESET_VAL(5'h1C)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .async_i({scl_i, sda_i, load_strobe_n_i, reset_n_i, reset_level_select_i}),
    .sync_o({scl_s, sda_s, ls_s, rst_pin_s, rsel_s})
  );

  // ==========================================================
  // edge detection on synchronised levels
  logic scl_q; // previous link clock
  logic sda_q; // previous link data
  logic ls_q; // previous load strobe

  // delayed copies for edge finding
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ls_q <= 1'b1;
    end else if (clk_en_i) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      ls_q <= ls_s;
    end
  end

  logic scl_rise; // sample point for data bits
  logic scl_fall; // change point for the acknowledge
  logic start_cond; // data falls while clock high
  logic stop_cond; // data rises while clock high
  logic ls_fall; // strobe high-to-low transition

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_cond = scl_s & scl_q & ~sda_s & sda_q;
  assign stop_cond = scl_s & scl_q & sda_s & ~sda_q;
  assign ls_fall = ~ls_s & ls_q;

  // ==========================================================
  // serial receiver: address byte, then bytes in groups of three
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_BITS,
    RX_ACK
  } qdac_rx_state_type;

  qdac_rx_state_type rx_state; // receiver phase
  logic [3:0] bit_cnt; // bits of the current byte taken
  logic [1:0] byte_idx; // 0 command, 1 msb, 2 lsb
  logic addr_phase; // first byte after a start
  logic [qdac_pkg::WORD_BITS-1:0] shift; // incoming bits, msb first
  logic ack_drive; // pull sda low for the acknowledge

  // receiver sequencing; start and stop override any phase
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_state <= RX_IDLE;
      bit_cnt <= '0;
      byte_idx <= '0;
      addr_phase <= 1'b0;
      ack_drive <= 1'b0;
    end else if (clk_en_i) begin
      if (start_cond) begin
        // also serves a repeated start
        rx_state <= RX_BITS;
        bit_cnt <= '0;
        byte_idx <= '0;
        addr_phase <= 1'b1;
        ack_drive <= 1'b0;
      end else if (stop_cond) begin
        // a partial word is dropped, nothing is applied
        rx_state <= RX_IDLE;
        ack_drive <= 1'b0;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            ack_drive <= 1'b0;
          end
          RX_BITS: begin
            if (scl_rise && bit_cnt != qdac_pkg::BYTE_BITS) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == qdac_pkg::BYTE_BITS) begin
              bit_cnt <= '0;
              if (addr_phase) begin
                // only writes to our address are acknowledged; reads
                // belong elsewhere, so the byte is left unanswered
                if (shift[7:1] == DEV_ADDR && !shift[0]) begin
                  rx_state <= RX_ACK;
                  ack_drive <= 1'b1;
                  addr_phase <= 1'b0;
                end else begin
                  rx_state <= RX_IDLE;
                end
              end else begin
                rx_state <= RX_ACK;
                ack_drive <= 1'b1;
                // command, msb, lsb, then the next word
                byte_idx <= (byte_idx == qdac_pkg::LAST_BYTE) ? 2'h0 : byte_idx + 2'h1;
              end
            end
          end
          RX_ACK: begin
            if (scl_fall) begin
              ack_drive <= 1'b0;
              rx_state <= RX_BITS;
            end
          end
          default: begin
            rx_state <= RX_IDLE;
            ack_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  // shift register, msb first
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift <= '0;
    end else if (clk_en_i) begin
      if (rx_state == RX_BITS && scl_rise && bit_cnt != qdac_pkg::BYTE_BITS) begin
        shift <= {shift[qdac_pkg::WORD_BITS-2:0], sda_s};
      end
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = ack_drive;

  // ==========================================================
  // word capture on the 24th rising clock of the data bytes
  logic word_valid; // one-cycle pulse, word below is complete
  logic [qdac_pkg::WORD_BITS-1:0] word; // captured command word
  logic last_bit; // 24th data clock is rising now

  assign last_bit = (rx_state == RX_BITS) && !addr_phase && scl_rise &&
                    bit_cnt == qdac_pkg::LAST_BIT && byte_idx == qdac_pkg::LAST_BYTE;

  // acts on the 24th clock itself, not on the acknowledge or stop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_valid <= 1'b0;
      word <= '0;
    end else if (clk_en_i) begin
      word_valid <= last_bit;
      if (last_bit) begin
        word <= {shift[qdac_pkg::WORD_BITS-2:0], sda_s};
      end
    end
  end

  // field split of the captured word
  logic [3:0] cmd; // command nibble
  logic [qdac_pkg::NUM_CH-1:0] chan_sel; // one bit per channel
  logic [DATA_W-1:0] data; // msb aligned data field

  assign cmd = word[qdac_pkg::CMD_MSB:qdac_pkg::CMD_LSB];
  assign chan_sel = word[qdac_pkg::ADDR_MSB:qdac_pkg::ADDR_LSB];
  assign data = word[qdac_pkg::DATA_MSB -: DATA_W];

  // ==========================================================
  // power-on and reset control
  logic por_busy; // initialising; held while reset pin low
  logic hold_clear; // registers forced to the clear code
  logic [DATA_W-1:0] clear_code; // selected power-up level
  logic cmd_ok; // a word that may act

  // the pin is a level, so a pulse shorter than two clocks may be missed;
  // the 30 ns minimum pulse is only about one cycle at this clock
  assign hold_clear = por_busy | ~rst_pin_s;
  assign cmd_ok = word_valid & ~hold_clear;

  // initialisation ends only once the reset pin reads high
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_busy <= 1'b1;
    end else if (clk_en_i) begin
      if (cmd_ok && cmd == qdac_pkg::CMD_SOFT_RESET) begin
        por_busy <= 1'b1;
      end else if (rst_pin_s) begin
        por_busy <= 1'b0;
      end
    end
  end

  // level select is tracked every cycle, so a one-cycle soft reset clear
  // already sees the current pin instead of a stale code
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clear_code <= '0;
    end else if (clk_en_i) begin
      // midscale is the top bit alone; zero scale is all zero
      clear_code <= rsel_s ? {1'b1, {(DATA_W-1){1'b0}}} : '0;
    end
  end

  assign init_busy_o = por_busy;

  // ==========================================================
  // channel update mask
  logic [qdac_pkg::NUM_CH-1:0] channel_update_mask; // bit n set: channel ignores strobe

  // only the power-on path restores the default; the pin clears the channel registers only
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      channel_update_mask <= qdac_pkg::MASK_RESET;
    end else if (clk_en_i) begin
      if (por_busy) begin
        channel_update_mask <= qdac_pkg::MASK_RESET;
      end else if (cmd_ok && cmd == qdac_pkg::CMD_MASK) begin
        // address nibble plays no part here
        channel_update_mask <= word[qdac_pkg::MASK_MSB:0];
      end
    end
  end

  // ==========================================================
  // per-channel update decode
  logic strobe_ok; // a strobe edge that may act
  logic is_write_in; // write input register only
  logic is_update; // copy input to converter
  logic is_write_upd; // write both

  // strobe is sampled, not a true asynchronous load: edges are seen
  // two to three clocks late, and pulses under two clocks may vanish
  assign strobe_ok = ls_fall & ~hold_clear;
  assign is_write_in = cmd_ok && cmd == qdac_pkg::CMD_WRITE_INPUT;
  assign is_update = cmd_ok && cmd == qdac_pkg::CMD_UPDATE;
  assign is_write_upd = cmd_ok && cmd == qdac_pkg::CMD_WRITE_UPDATE;

  for (genvar ch = 0; ch < qdac_pkg::NUM_CH; ch++) begin : g_chan
    qdac_chan_if #(.DATA_W(DATA_W)) chan_bus ();

    assign chan_bus.clear = hold_clear;
    assign chan_bus.clear_code = clear_code;
    assign chan_bus.data = data;
    // input register takes data on either write command
    assign chan_bus.load_input = chan_sel[ch] & (is_write_in | is_write_upd);
    // strobe held low: write-input goes straight through, mask not consulted
    assign chan_bus.dac_from_data = chan_sel[ch] & (is_write_upd | (is_write_in & ~ls_s));
    // update command, or a strobe edge on an unmasked channel
    assign chan_bus.dac_from_input = (chan_sel[ch] & is_update) |
                                     (strobe_ok & ~channel_update_mask[ch]);
    assign dac_code_o[ch*DATA_W +: DATA_W] = chan_bus.dac_code;

    qdac_channel #(
      .DATA_W(DATA_W)
    ) u_chan (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .clk_en_i(clk_en_i),
      .bus(chan_bus.chan)
    );
  end

endmodule : qdac_ctrl
`default_nettype wire

//--- testbench/qdac_ctrl_chk.sv
// qdac_ctrl_chk: port-level assertions for the update and reset control.
// assumes one clock domain, clk_en_i high, scl at a 200 ns period.
`timescale 1ns/100ps
`default_nettype none
module qdac_ctrl_chk #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // serial link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // pins and converter side
  input wire logic load_strobe_n_i,
  input wire logic reset_n_i,
  input wire logic reset_level_select_i,
  input wire logic [qdac_pkg::NUM_CH*DATA_W-1:0] dac_code_o,
  input wire logic init_busy_o
);
  // ==========================================
  // helpers
  logic [DATA_W-1:0] clr_code; // code picked by the select pin
  assign clr_code = reset_level_select_i ? {1'b1, {(DATA_W-1){1'b0}}} : '0;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================
  // sequences: pin held long enough to cross the synchroniser
  sequence s_pin_low;
    (!reset_n_i && clk_en_i && $stable(reset_level_select_i))[*6];
  endsequence
  sequence s_busy_long;
    (init_busy_o && $stable(reset_level_select_i))[*6];
  endsequence
  sequence s_quiet;
    ($stable(scl_i) && load_strobe_n_i && reset_n_i && !init_busy_o && $stable(reset_level_select_i))[*7];
  endsequence
  // ==========================================
  // properties
  property p_sda_low;
    sda_o == 1'b0;
  endproperty
  property p_ack;
    $rose(sda_oe_o) |-> sda_oe_o[*5] ##[1:8] !sda_oe_o;
  endproperty
  property p_rst_clear;
    s_pin_low |-> dac_code_o == {qdac_pkg::NUM_CH{clr_code}};
  endproperty
  property p_rst_hold;
    s_pin_low |=> $stable(dac_code_o);
  endproperty
  property p_init_wait;
    (!reset_n_i)[*3] ##0 init_busy_o |=> init_busy_o;
  endproperty
  property p_powerup;
    $stable(reset_level_select_i)[*4] ##0 $fell(init_busy_o) |=> dac_code_o == {qdac_pkg::NUM_CH{$past(clr_code)}};
  endproperty
  property p_busy_quiet;
    s_busy_long |=> $stable(dac_code_o);
  endproperty
  property p_quiet;
    s_quiet |=> $stable(dac_code_o);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  a_ack: assert property (p_ack) else $error("acknowledge length wrong");
  a_rst_clear: assert property (p_rst_clear) else $error("reset pin did not clear");
  a_rst_hold: assert property (p_rst_hold) else $error("update under reset pin");
  a_init_wait: assert property (p_init_wait) else $error("init ended with pin low");
  a_powerup: assert property (p_powerup) else $error("wrong power-up code");
  a_busy_quiet: assert property (p_busy_quiet) else $error("update while initialising");
  a_quiet: assert property (p_quiet) else $error("word changed without cause");
endmodule : qdac_ctrl_chk
`default_nettype wire

//--- testbench/qdac_i2c_master.sv
// qdac_i2c_master: behavioural two-wire controller that sends write words.
// assumes the bench resolves sda with a pull-up; scl idles high.
`timescale 1ns/100ps
`default_nettype none
module qdac_i2c_master #(
  parameter logic [6:0] ADDR = 7'h0C // bus address of the device
) (
  // wire seen and wires driven
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  int nack_count; // bytes left unanswered
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    nack_count = 0;
  end
  // ==========================================
  // one bit: sda moves mid-low, sampled late in high
  task automatic bit_cycle(input logic pull, output logic seen);
    sda_oe_o = pull;
    #50;
    scl_o = 1'b1;
    #100;
    seen = sda_i;
    scl_o = 1'b0;
    #50;
  endtask : bit_cycle
  // eight bits, then a released ninth for the acknowledge
  task automatic put_byte(input logic [7:0] b);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~b[i], seen);
    end
    bit_cycle(1'b0, seen);
    if (seen) nack_count++;
  endtask : put_byte
  // start, address, command byte, msb, lsb, stop
  task automatic write_word(input logic [23:0] w);
    sda_oe_o = 1'b1; // start under high scl
    #100;
    scl_o = 1'b0;
    #50;
    put_byte({ADDR, 1'b0});
    put_byte(w[23:16]);
    put_byte(w[15:8]);
    put_byte(w[7:0]);
    sda_oe_o = 1'b1;
    #50;
    scl_o = 1'b1; // stop: sda rises under high scl
    #100;
    sda_oe_o = 1'b0;
    #100;
  endtask : write_word
endmodule : qdac_i2c_master
`default_nettype wire

//--- testbench/test_qdac_ctrl.sv
// test_qdac_ctrl: self-checking bench for the update and reset control.
// assumes DATA_W 16; expected words queued before each stimulus.
`timescale 1ns/100ps
`default_nettype none
module test_qdac_ctrl;
  localparam int W = 16;
  logic ref_clk_i, arst_n_i, clk_en_i, strobe_n, rst_n, sel, m_scl, m_oe, d_sda, d_oe, busy, mon_en;
  wire sda_w; // pulled up unless someone pulls low
  logic [4*W-1:0] code, last, cur;
  logic [4*W-1:0] notes[$]; // expected converter words, oldest first
  logic [W-1:0] e_in[4], e_dac[4];
  logic [3:0] e_mask;
  logic [31:0] rnd;
  logic [W-1:0] rv; // scratch random word
  int bad_count, n_compared, cycles;
  assign sda_w = !(m_oe || (d_oe && !d_sda));
  // ==========================================
  // design and partner
  qdac_ctrl #(.DATA_W(W)) i_qdac_ctrl (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en_i),
    .scl_i(m_scl), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_o(d_oe), .load_strobe_n_i(strobe_n),
    .reset_n_i(rst_n), .reset_level_select_i(sel), .dac_code_o(code), .init_busy_o(busy));
  qdac_i2c_master #(.ADDR(qdac_pkg::DEV_ADDR_DEFAULT)) i_qdac_i2c_master (.sda_i(sda_w), .scl_o(m_scl),
    .sda_oe_o(m_oe));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================
  // helpers
  function automatic logic [W-1:0] rnd16();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[W-1:0];
  endfunction : rnd16
  function automatic logic [W-1:0] clr(input logic s);
    return s ? {1'b1, {(W-1){1'b0}}} : '0;
  endfunction : clr
  function automatic logic [4*W-1:0] pack();
    return {e_dac[3], e_dac[2], e_dac[1], e_dac[0]};
  endfunction : pack
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [4*W-1:0] got, input logic [4*W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // queue the model word only when it really changes
  task automatic note();
    if (pack() !== cur) begin
      cur = pack();
      notes.push_back(cur);
    end
  endtask : note
  task automatic set_all(input logic [W-1:0] v);
    for (int n = 0; n < 4; n++) begin
      e_in[n] = v;
      e_dac[n] = v;
    end
  endtask : set_all
  // power-up with the reset pin low, released later
  task automatic boot(input logic s);
    mon_en = 1'b0;
    arst_n_i = 1'b0;
    rst_n = 1'b0;
    sel = s;
    tick(2);
    arst_n_i = 1'b1;
    tick(6);
    check("busy with pin low", busy, 1);
    rst_n = 1'b1;
    tick(8);
    check("busy after release", busy, 0);
    e_mask = '0;
    set_all(clr(s));
    cur = pack();
    check("power-up code", code, cur);
    mon_en = 1'b1;
  endtask : boot
  // one command word; model first, so the note precedes the change
  task automatic wr(input logic [3:0] c, input logic [3:0] s, input logic [W-1:0] d);
    if (rst_n && c == qdac_pkg::CMD_MASK) e_mask = d[3:0];
    if (rst_n && c == qdac_pkg::CMD_SOFT_RESET) begin
      e_mask = '0;
      set_all(clr(sel));
    end
    for (int n = 0; n < 4; n++) begin
      if (rst_n && s[n] && c == qdac_pkg::CMD_UPDATE) e_dac[n] = e_in[n];
      if (rst_n && s[n] && (c == qdac_pkg::CMD_WRITE_UPDATE || (c == qdac_pkg::CMD_WRITE_INPUT && !strobe_n))) begin
        e_dac[n] = d;
      end
      if (rst_n && s[n] && (c == qdac_pkg::CMD_WRITE_INPUT || c == qdac_pkg::CMD_WRITE_UPDATE)) e_in[n] = d;
    end
    note();
    i_qdac_i2c_master.write_word({c, s, d});
    tick(12);
  endtask : wr
  // strobe level; a fall copies unmasked channels
  task automatic strobe(input logic lvl);
    for (int n = 0; n < 4; n++) begin
      if (!lvl && strobe_n && rst_n && !e_mask[n]) e_dac[n] = e_in[n];
    end
    note();
    strobe_n = lvl;
    tick(6);
  endtask : strobe
  // ==========================================
  // watcher: each change of the word consumes the oldest note
  always @(posedge ref_clk_i) begin
    if (mon_en && code !== last) begin
      if (notes.size() == 0) check("unexpected change", code, last);
      else check("converter word", code, notes.pop_front());
    end
    last <= code;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    arst_n_i = 1'b0;
    clk_en_i = 1'b1;
    strobe_n = 1'b1;
    rst_n = 1'b0;
    sel = 1'b0;
    mon_en = 1'b0;
    rnd = 32'd66460;
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    boot(1'b0);
    wr(qdac_pkg::CMD_WRITE_INPUT, 4'h3, rnd16());
    strobe(1'b0);
    strobe(1'b1);
    rv = rnd16();
    wr(qdac_pkg::CMD_MASK, rv[7:4], {rv[W-1:4], 4'h5});
    wr(qdac_pkg::CMD_WRITE_INPUT, 4'hF, rnd16());
    strobe(1'b0);
    strobe(1'b1);
    wr(qdac_pkg::CMD_UPDATE, 4'h1, rnd16());
    strobe(1'b0);
    wr(qdac_pkg::CMD_WRITE_INPUT, 4'hF, rnd16());
    strobe(1'b1);
    wr(qdac_pkg::CMD_WRITE_UPDATE, 4'h8, rnd16());
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {[1:3], 5, 6})) wr(c[3:0], 4'hF, rnd16());
    end
    sel = 1'b1;
    tick(4);
    wr(qdac_pkg::CMD_SOFT_RESET, 4'h0, rnd16());
    wr(qdac_pkg::CMD_WRITE_INPUT, 4'hF, rnd16());
    strobe(1'b0);
    strobe(1'b1);
    set_all(clr(sel));
    note();
    rst_n = 1'b0;
    tick(8);
    wr(qdac_pkg::CMD_WRITE_UPDATE, 4'hF, rnd16());
    rst_n = 1'b1;
    tick(8);
    wr(qdac_pkg::CMD_WRITE_UPDATE, 4'hF, rnd16());
    boot(1'b1);
    tick(20);
    check("pending notes", notes.size(), 0);
    check("missed acknowledges", i_qdac_i2c_master.nack_count, 0);
    report_and_stop();
  end
endmodule : test_qdac_ctrl
bind qdac_ctrl qdac_ctrl_chk #(.DATA_W(DATA_W)) i_qdac_ctrl_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
  .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .load_strobe_n_i(load_strobe_n_i), .reset_n_i(reset_n_i), .reset_level_select_i(reset_level_select_i),
  .dac_code_o(dac_code_o), .init_busy_o(init_busy_o));
`default_nettype wire
